// ===== design/adc_ctrl_pkg.sv
// Purpose: constants, types and bus carriers of the converter control block
// Assumes: 8-bit registers in the low byte of 32-bit aligned AXI4-Lite words
// Notes:   one clock; the converter clock is derived from clk by the divider
package adc_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] SC2_OFS    = 8'h04;
  localparam logic [7:0] SC1_OFS    = 8'h08;
  localparam logic [7:0] RESH_OFS   = 8'h0c;
  localparam logic [7:0] RESL_OFS   = 8'h10;
  localparam logic [7:0] CVH_OFS    = 8'h14;
  localparam logic [7:0] CVL_OFS    = 8'h18;

  // converter_config fields
  localparam int unsigned CFG_LOWPOWER_BIT = 7;
  localparam int unsigned CFG_DIV_LSB      = 5;
  localparam int unsigned CFG_LONG_BIT     = 4;
  localparam int unsigned CFG_MODE_LSB     = 2;
  localparam int unsigned CFG_CLK_LSB      = 0;
  // converter_status_control_two fields
  localparam int unsigned SC2_ACTIVE_BIT = 7;
  localparam int unsigned SC2_TRIG_BIT   = 6;
  localparam int unsigned SC2_CMPEN_BIT  = 5;
  localparam int unsigned SC2_CMPGT_BIT  = 4;
  // converter_status_control_one fields
  localparam int unsigned SC1_DONE_BIT  = 7;
  localparam int unsigned SC1_IRQEN_BIT = 6;
  localparam int unsigned SC1_CONT_BIT  = 5;
  localparam int unsigned SC1_CH_LSB    = 0;

  // field encodings
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] CLK_ASYNC  = 2'h3;
  localparam logic [4:0] CHAN_OFF   = 5'h1f;

  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [2:0] SC2_RST    = 3'h0;
  localparam logic [6:0] SC1_RST    = 7'h1f;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [9:0] CV_RST     = 10'h000;

  // conversion lengths in converter clock cycles
  localparam logic [5:0] CNT_SHORT8  = 6'h14;
  localparam logic [5:0] CNT_SHORT10 = 6'h17;
  localparam logic [5:0] CNT_LONG8   = 6'h28;
  localparam logic [5:0] CNT_LONG10  = 6'h2b;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_CONV = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage : adc_ctrl_pkg

// ===== design/adc_low_power_ctrl.sv
// Purpose: converter control with stop-mode behaviour behind an AXI4-Lite slave
// Assumes: stop3/stop12 levels come from the power controller, synchronous to clk
// Notes:   the analog front end delivers analogSample; irq wakes the MCU
// Function
// - stop3 without async clock aborts to idle
// - results survive stop3 entry and exit
// - after such stop3, new trigger needed
// - async clock keeps conversions running in stop3
// - hardware trigger or continuous starts in stop3 with async clock
// - completion sets flag, enabled interrupt wakes
// - stop1/stop2 disable and reset all registers
// - config bit7 low power, bit4 long sample
// - config bits 6:5 divider, 00 divides one
// - config bits 3:2 resolution, 10 ten-bit
// - config bits 1:0 clock, 00 bus
// - control two bit7 shows conversion active
// - control two bit6 clear selects software trigger
// - bit5 compare enable, bit4 compare direction
// - bits 3:2 read zero, 1:0 written zero
// - control one bit7 read-only complete flag
// - control one bit6 enables complete interrupt
// - control one bit5 selects continuous conversions
// - control one bits 4:0 select channel
// - control one write aborts, restarts in software trigger mode unless off
`timescale 1ns/1ps
module adc_low_power_ctrl (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // register bus
  input  wire adc_ctrl_pkg::axil_req_t axiReq,
  output adc_ctrl_pkg::axil_rsp_t      axiRsp,
  // power modes and trigger
  input  wire logic                   stop3,
  input  wire logic                   stop12,
  input  wire logic                   hwTrigger,
  // analog front end
  input  wire logic [9:0]             analogSample,
  output logic [4:0]                  channelSel,
  output logic                        lowPowerSel,
  // interrupt request
  output logic                        irq
);
  import adc_ctrl_pkg::*;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == CONFIG_OFS) || (a == SC2_OFS) || (a == SC1_OFS) || (a == RESH_OFS) ||
               (a == RESL_OFS) || (a == CVH_OFS) || (a == CVL_OFS);
  endfunction : isMapped

  // bus state
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic              awHeld_r, wHeld_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  // registers
  logic [7:0]        cfg_r;
  logic [2:0]        sc2_r;
  logic [6:0]        sc1_r;
  logic              completeFlag_r;
  logic [9:0]        result_r, cv_r;
  // converter
  conv_state_t       state_r;
  logic [5:0]        cnt_r;
  logic [2:0]        divCnt_r;
  logic              stop3Prev_r, irq_r;

  assign axiRsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r, bresp: bresp_r,
                    arready: arready_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};
  assign irq         = irq_r;
  assign channelSel  = sc1_r[SC1_CH_LSB +: 5];
  assign lowPowerSel = cfg_r[CFG_LOWPOWER_BIT];

  // handshakes and write decode
  wire awHs   = axiReq.awvalid & awready_r;
  wire wHs    = axiReq.wvalid & wready_r;
  wire arHs   = axiReq.arvalid & arready_r;
  wire wrFire = awHeld_r & wHeld_r & ~bvalid_r;
  wire wrOk   = wrFire & isMapped(awaddr_r);
  wire wrByte = wrOk & wlane_r;
  wire wrCfg  = wrByte & (awaddr_r == CONFIG_OFS);
  wire wrSc2  = wrByte & (awaddr_r == SC2_OFS);
  wire wrSc1  = wrByte & (awaddr_r == SC1_OFS);
  wire wrCvh  = wrByte & (awaddr_r == CVH_OFS);
  wire wrCvl  = wrByte & (awaddr_r == CVL_OFS);
  wire wrAny  = wrCfg | wrSc2 | wrSc1 | wrCvh | wrCvl;
  wire rdResl = arHs & (axiReq.araddr == RESL_OFS);

  wire       longSample = cfg_r[CFG_LONG_BIT];
  wire [1:0] divSel     = cfg_r[CFG_DIV_LSB +: 2];
  wire       mode10     = cfg_r[CFG_MODE_LSB +: 2] == MODE_10BIT;
  wire       asyncSel   = cfg_r[CFG_CLK_LSB +: 2] == CLK_ASYNC;
  wire       hwTrigSel  = sc2_r[2];
  wire       cmpEn      = sc2_r[1];
  wire       cmpGt      = sc2_r[0];
  wire       irqEn      = sc1_r[SC1_IRQEN_BIT];
  wire       contSel    = sc1_r[SC1_CONT_BIT];
  wire       chanOn     = sc1_r[SC1_CH_LSB +: 5] != CHAN_OFF;
  wire       chanOnWr   = wbyte_r[SC1_CH_LSB +: 5] != CHAN_OFF;

  // converter clock divider: 1, 2, 4 or 8
  wire [2:0] divMax   = 3'((4'h1 << divSel) - 4'h1);
  wire       adckTick = divCnt_r == divMax;
  wire [5:0] convLen  = longSample ? (mode10 ? CNT_LONG10 : CNT_LONG8)
                                   : (mode10 ? CNT_SHORT10 : CNT_SHORT8);
  wire       converting = state_r == S_CONV;
  wire       idle       = state_r == S_IDLE;

  // stop3 entry with bus-derived clock aborts
  wire stop3Abort = stop3 & ~stop3Prev_r & ~asyncSel;
  // hardware triggers ignored while in stop3 on bus clock
  wire stop3Hold  = stop3 & ~asyncSel;
  wire abortConv  = wrAny | stop3Abort;
  wire done       = converting & adckTick & (cnt_r == 6'h01) & ~abortConv;

  // compare against the result at the selected resolution
  wire [9:0] sampleVal = mode10 ? analogSample : {2'h0, analogSample[9:2]};
  wire       geq       = sampleVal >= cv_r;
  wire       cmpPass   = ~cmpEn | (cmpGt ? geq : ~geq);
  wire       resultLoad = done & cmpPass;

  // control one write restarts in software trigger mode unless channel off
  wire startSw  = wrSc1 & ~sc2_r[2] & chanOnWr;
  wire startHw  = idle & hwTrigSel & hwTrigger & chanOn & ~stop3Hold & ~abortConv;
  // continuous mode restarts after each completion
  wire startCont = done & contSel;
  wire startAny = startSw | startHw | startCont;

  wire completeClr = wrSc1 | rdResl;
  wire completeNxt = resultLoad | (completeFlag_r & ~completeClr);
  wire irqEnNxt    = wrSc1 ? wbyte_r[SC1_IRQEN_BIT] : irqEn;

  // read mux
  wire [7:0] rdByte =
    (axiReq.araddr == CONFIG_OFS) ? cfg_r :
    // active flag; bits 3:0 read zero
    (axiReq.araddr == SC2_OFS)    ? {converting, sc2_r, 4'h0} :
    (axiReq.araddr == SC1_OFS)    ? {completeFlag_r, sc1_r} :
    (axiReq.araddr == RESH_OFS)   ? {6'h00, result_r[9:8]} :
    (axiReq.araddr == RESL_OFS)   ? result_r[7:0] :
    (axiReq.araddr == CVH_OFS)    ? {6'h00, cv_r[9:8]} :
    (axiReq.araddr == CVL_OFS)    ? cv_r[7:0] : 8'h00;
  wire rdOk = isMapped(axiReq.araddr);

  // write channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awaddr_r  <= '0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (awHs) begin
        awaddr_r  <= axiReq.awaddr;
        awHeld_r  <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wHs) begin
        wbyte_r  <= axiReq.wdata[7:0];
        wlane_r  <= axiReq.wstrb[0];
        wHeld_r  <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wrFire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wrOk ? RESP_OKAY : RESP_DECERR;
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
      end
      if (bvalid_r & axiReq.bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (arHs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h00_0000, rdByte};
      rresp_r   <= rdOk ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r & axiReq.rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CONFIG_RST;
      sc2_r <= SC2_RST;
      sc1_r <= SC1_RST;
      cv_r  <= CV_RST;
    end else if (stop12) begin
      cfg_r <= CONFIG_RST;
      sc2_r <= SC2_RST;
      sc1_r <= SC1_RST;
      cv_r  <= CV_RST;
    end else begin
      if (wrCfg) cfg_r <= wbyte_r;
      if (wrSc2) sc2_r <= wbyte_r[6:4];
      if (wrSc1) sc1_r <= wbyte_r[6:0];
      if (wrCvh) cv_r[9:8] <= wbyte_r[1:0];
      if (wrCvl) cv_r[7:0] <= wbyte_r;
    end
  end

  // result only changes on a completed conversion or a stop1/stop2 reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r       <= RESULT_RST;
      completeFlag_r <= 1'b0;
      irq_r          <= 1'b0;
    end else if (stop12) begin
      result_r       <= RESULT_RST;
      completeFlag_r <= 1'b0;
      irq_r          <= 1'b0;
    end else begin
      if (resultLoad) result_r <= sampleVal;
      completeFlag_r <= completeNxt;
      irq_r          <= completeNxt & irqEnNxt;
    end
  end

  // conversion state machine, keeps running on async clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= S_IDLE;
      cnt_r       <= 6'h00;
      divCnt_r    <= 3'h0;
      stop3Prev_r <= 1'b0;
    end else begin
      stop3Prev_r <= stop3;
      divCnt_r    <= (adckTick | startAny) ? 3'h0 : 3'(divCnt_r + 3'h1);
      if (stop12) begin
        state_r <= S_IDLE;
        cnt_r   <= 6'h00;
      end else if (startAny) begin
        state_r <= S_CONV;
        cnt_r   <= convLen;
      end else if (abortConv | done) begin
        state_r <= S_IDLE;
        cnt_r   <= 6'h00;
      end else if (converting & adckTick) begin
        cnt_r <= 6'(cnt_r - 6'h01);
      end
    end
  end

  AST_STOP3_ABORT: assert property (@(posedge clk) disable iff (rst)
    (stop3 && !stop3Prev_r && !asyncSel && converting && !wrAny && !stop12) |=> idle)
    else $error("conversion survived stop3 entry on bus clock");

  AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (rst)
    (!resultLoad && !stop12) |=> $stable(result_r))
    else $error("result changed without a completed conversion");

  // no start except by a control one write while held in stop3
  AST_STOP3_IDLE: assert property (@(posedge clk) disable iff (rst)
    (stop3Hold && idle && !wrSc1) |=> idle)
    else $error("conversion started while held in stop3");

  AST_ASYNC_RUN: assert property (@(posedge clk) disable iff (rst)
    (stop3 && asyncSel && converting && !wrAny && !stop12 && !done) |=> converting)
    else $error("async conversion stopped in stop3");

  AST_HW_START: assert property (@(posedge clk) disable iff (rst)
    (idle && hwTrigSel && hwTrigger && chanOn && !stop3Hold && !wrAny && !stop12)
    |=> converting && cnt_r == $past(convLen))
    else $error("hardware trigger ignored");

  AST_DONE_IRQ: assert property (@(posedge clk) disable iff (rst)
    (resultLoad && !stop12) |=> completeFlag_r && (irq_r == irqEn))
    else $error("completion did not set flag or interrupt");

  AST_STOP12_RESET: assert property (@(posedge clk) disable iff (rst)
    stop12 |=> (cfg_r == CONFIG_RST) && (sc1_r == SC1_RST) && !completeFlag_r
      && idle && !irq_r)
    else $error("registers not reset by stop1 or stop2");

  AST_ACTIVE_READ: assert property (@(posedge clk) disable iff (rst)
    (arHs && axiReq.araddr == SC2_OFS) |=> rdata_r[SC2_ACTIVE_BIT] == $past(converting)
      && rdata_r[3:0] == 4'h0)
    else $error("active flag or reserved bits read wrong");

  AST_SC1_RESTART: assert property (@(posedge clk) disable iff (rst)
    (wrSc1 && !sc2_r[2] && chanOnWr && !stop12) |=> converting ##1 converting)
    else $error("control one write did not start a conversion");

  // hardware trigger mode, write only aborts
  AST_TRIG_SELECT: assert property (@(posedge clk) disable iff (rst)
    (wrSc1 && hwTrigSel && !stop12) |=> idle)
    else $error("control one write started a conversion in hardware trigger mode");

  AST_CMP_SUPPRESS: assert property (@(posedge clk) disable iff (rst)
    (done && cmpEn && !cmpPass && !completeFlag_r && !stop12) |=> !completeFlag_r)
    else $error("failed compare set the complete flag");

  AST_CONT_RESTART: assert property (@(posedge clk) disable iff (rst)
    (done && contSel && !stop12) |=> converting && cnt_r == $past(convLen))
    else $error("continuous conversion did not restart");

endmodule : adc_low_power_ctrl

// ===== verification/adc_low_power_ctrl_test.sv
// Purpose: self-checking bench for the converter control block
// Assumes: bus or async clock source, compare blocking in one test, offsets from the package
// Notes:   every scenario is its own task, driven at the rising edge
`timescale 1ns/1ps
module adc_low_power_ctrl_test;
  import adc_ctrl_pkg::*;

  logic       clk;
  logic       rst;
  axil_req_t  req;
  axil_rsp_t  rsp;
  logic       stop3;
  logic       stop12;
  logic       hwTrigger;
  logic [9:0] sample;
  logic [4:0] chan;
  logic       lowPower;
  logic       irq;
  logic [31:0] rd;
  logic [1:0] resp;
  int         errTotal;
  int         comparisons;
  int         cyc;

  adc_low_power_ctrl adc_low_power_ctrl_i (
    .clk         (clk),
    .rst         (rst),
    .axiReq      (req),
    .axiRsp      (rsp),
    .stop3       (stop3),
    .stop12      (stop12),
    .hwTrigger   (hwTrigger),
    .analogSample(sample),
    .channelSel  (chan),
    .lowPowerSel (lowPower),
    .irq         (irq)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // entered just after an edge; leaves one edge after the response
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hf;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!(rsp.bvalid && req.bready));
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!(rsp.rvalid && req.rready));
    rd   = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clk);
    chk(what, rd, exp);
  endtask : rc

  task automatic waitIrq();
    cyc = 0;
    while (irq !== 1'b1 && cyc < 200) begin
      @(posedge clk);
      cyc++;
    end
  endtask : waitIrq

  task automatic t_reset();
    rc("config", CONFIG_OFS, 32'h00);
    rc("two", SC2_OFS, 32'h00);
    rc("one", SC1_OFS, 32'h1f);
    rc("unmapped", 8'h1c, 32'h00);
    chk("unmapped resp", {30'h0, resp}, {30'h0, RESP_DECERR});
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    wr(CONFIG_OFS, 8'h98);
    rc("config", CONFIG_OFS, 32'h98);
    chk("lowPower", {31'h0, lowPower}, 32'h1);
    wr(SC2_OFS, 8'hfc);
    rc("two ro", SC2_OFS, 32'h70);
    wr(SC2_OFS, 8'h00);
    $display("test config done");
  endtask : t_config

  task automatic t_single(input logic [7:0] cfg, input int n,
                          input logic [7:0] hi, input logic [7:0] lo);
    sample <= 10'h2a5;
    wr(CONFIG_OFS, cfg);
    wr(SC1_OFS, 8'h41);
    chk("chan", {27'h0, chan}, 32'h01);
    rc("active", SC2_OFS, 32'h80);
    waitIrq();
    chk("length", {31'h0, (cyc >= n - 6 && cyc <= n + 2)}, 32'h1);
    rc("flag", SC1_OFS, 32'hc1);
    chk("irq", {31'h0, irq}, 32'h1);
    rc("high", RESH_OFS, {24'h0, hi});
    rc("low", RESL_OFS, {24'h0, lo});
    chk("irq off", {31'h0, irq}, 32'h0);
    rc("idle", SC2_OFS, 32'h00);
    $display("test single %0d done", n);
  endtask : t_single

  task automatic t_stop3Off();
    sample <= 10'h15a;
    wr(CONFIG_OFS, 8'h98);
    wr(SC1_OFS, 8'h41);
    stop3 <= 1'b1;
    waitIrq();
    chk("aborted", cyc, 200);
    rc("idle", SC2_OFS, 32'h00);
    stop3 <= 1'b0;
    repeat (60) @(posedge clk);
    chk("stays idle", {31'h0, irq}, 32'h0);
    rc("kept low", RESL_OFS, 32'ha9);
    wr(SC1_OFS, 8'h41);
    waitIrq();
    rc("new high", RESH_OFS, 32'h01);
    rc("new low", RESL_OFS, 32'h5a);
    $display("test stop3 bus clock done");
  endtask : t_stop3Off

  task automatic t_stop3Async();
    wr(CONFIG_OFS, 8'h9b);
    wr(SC1_OFS, 8'h41);
    stop3 <= 1'b1;
    waitIrq();
    chk("runs in stop3", {31'h0, cyc < 200}, 32'h1);
    rc("low", RESL_OFS, 32'h5a);
    wr(SC2_OFS, 8'h40);
    wr(SC1_OFS, 8'h41);
    waitIrq();
    chk("no sw start", cyc, 200);
    sample    <= 10'h0c3;
    hwTrigger <= 1'b1;
    @(posedge clk);
    hwTrigger <= 1'b0;
    waitIrq();
    chk("hw start", {31'h0, cyc < 200}, 32'h1);
    rc("low", RESL_OFS, 32'hc3);
    stop3 <= 1'b0;
    wr(SC2_OFS, 8'h00);
    $display("test stop3 async done");
  endtask : t_stop3Async

  task automatic t_cont();
    wr(CONFIG_OFS, 8'h88);
    wr(SC1_OFS, 8'h61);
    waitIrq();
    rc("still active", SC2_OFS, 32'h80);
    wr(SC1_OFS, 8'h1f);
    rc("off idle", SC2_OFS, 32'h00);
    rc("low", RESL_OFS, 32'hc3);
    $display("test continuous done");
  endtask : t_cont

  task automatic t_compare();
    sample <= 10'h15a;
    wr(CVH_OFS, 8'h02);
    wr(CVL_OFS, 8'h00);
    wr(SC2_OFS, 8'h30);
    wr(SC1_OFS, 8'h41);
    waitIrq();
    chk("above fails", cyc, 200);
    rc("kept", RESL_OFS, 32'hc3);
    wr(SC2_OFS, 8'h20);
    wr(SC1_OFS, 8'h41);
    waitIrq();
    chk("below passes", {31'h0, cyc < 200}, 32'h1);
    rc("below low", RESL_OFS, 32'h5a);
    wr(SC2_OFS, 8'h00);
    $display("test compare done");
  endtask : t_compare

  task automatic t_stop12();
    wr(CONFIG_OFS, 8'h98);
    wr(SC1_OFS, 8'h41);
    stop12 <= 1'b1;
    @(posedge clk);
    stop12 <= 1'b0;
    rc("config", CONFIG_OFS, 32'h00);
    rc("one", SC1_OFS, 32'h1f);
    rc("two", SC2_OFS, 32'h00);
    rc("low", RESL_OFS, 32'h00);
    chk("chan", {27'h0, chan}, 32'h1f);
    chk("lowPower", {31'h0, lowPower}, 32'h0);
    wr(CONFIG_OFS, 8'h98);
    wr(SC2_OFS, 8'h00);
    wr(SC1_OFS, 8'h41);
    waitIrq();
    chk("reconfigured", {31'h0, irq}, 32'h1);
    rc("reconfigured low", RESL_OFS, 32'h5a);
    $display("test stop12 done");
  endtask : t_stop12

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    summarize();
  end

  initial begin
    errTotal    = 0;
    comparisons = 0;
    rst         = 1'b1;
    req         = '0;
    stop3       = 1'b0;
    stop12      = 1'b0;
    hwTrigger   = 1'b0;
    sample      = 10'h000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_config();
    t_single(8'h98, 43, 8'h02, 8'ha5);
    t_single(8'ha0, 40, 8'h00, 8'ha9);
    t_stop3Off();
    t_stop3Async();
    t_cont();
    t_compare();
    t_stop12();
    summarize();
  end
endmodule : adc_low_power_ctrl_test
